/* core/audio_port_clocking.v */
// Audio port clock generation, companding, loopback and multi-function pin
`timescale 1ns/1ns
`include "audio_port_map.vh"

module audio_port_clocking (
    input  wire        CLK_SYS,
    input  wire        RESET_N,
    input  wire        REG_WE,
    input  wire [6:0]  REG_ADDR,
    input  wire [8:0]  REG_WDATA,
    output reg  [8:0]  REG_RDATA,
    input  wire        MCLK,
    input  wire        PLL_OSC,
    input  wire        PLL_POST_DIV2,
    output reg         PLL_REF_CLK,
    output wire        PLL_ENABLE,
    output wire [3:0]  PLL_N,
    output wire [23:0] PLL_K,
    output reg         SYS_CLK_EN,
    output wire [2:0]  FILTER_RATE_CODE,
    input  wire        BCLK_IN,
    output reg         BCLK_OUT,
    output wire        BCLK_OE_N,
    input  wire        FRAME_IN,
    output reg         FRAME_OUT,
    output wire        FRAME_OE_N,
    input  wire        REC_VALID,
    input  wire [15:0] REC_SAMPLE,
    output reg         REC_WORD_VALID,
    output reg  [15:0] REC_WORD,
    input  wire        PLAY_VALID,
    input  wire [15:0] PLAY_WORD,
    output reg         PLAY_SAMPLE_VALID,
    output reg  [15:0] PLAY_SAMPLE,
    input  wire        CTRL_MODE,
    input  wire        JACK_DETECT,
    input  wire        TEMP_OK,
    input  wire        AUTO_MUTE,
    input  wire        PLL_LOCK,
    input  wire        MFP_IN,
    output reg         MFP_OUT,
    output wire        MFP_OE_N,
    output wire        CHIP_SELECT_N
);

    ////////////////////
    // Reset release

    reg        rst_meta_n;
    reg        rst_n;

    // Two-stage release of the asynchronous reset
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    ////////////////////
    // Register file

    reg  [8:0] power_control_one;
    reg  [8:0] compander_and_return_path;
    reg  [8:0] clock_generation;
    reg  [8:0] sample_rate_config;
    reg  [8:0] pin_function_control;
    reg  [8:0] pll_integer_ratio;
    reg  [8:0] pll_fraction_high;
    reg  [8:0] pll_fraction_mid;
    reg  [8:0] pll_fraction_low;
    wire       soft_reset;

    assign soft_reset = REG_WE && (REG_ADDR == `ADDR_SOFT_RESET);

    // Writes; index zero restores defaults
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            power_control_one         <= `RST_POWER_ONE;
            compander_and_return_path <= `RST_COMPANDER;
            clock_generation          <= `RST_CLOCK_GEN;
            sample_rate_config        <= `RST_SAMPLE_RATE;
            pin_function_control      <= `RST_PIN_FUNCTION;
            pll_integer_ratio         <= `RST_PLL_INTEGER;
            pll_fraction_high         <= `RST_PLL_FRAC_HIGH;
            pll_fraction_mid          <= `RST_PLL_FRAC_MID;
            pll_fraction_low          <= `RST_PLL_FRAC_LOW;
        end else if (soft_reset) begin
            power_control_one         <= `RST_POWER_ONE;
            compander_and_return_path <= `RST_COMPANDER;
            clock_generation          <= `RST_CLOCK_GEN;
            sample_rate_config        <= `RST_SAMPLE_RATE;
            pin_function_control      <= `RST_PIN_FUNCTION;
            pll_integer_ratio         <= `RST_PLL_INTEGER;
            pll_fraction_high         <= `RST_PLL_FRAC_HIGH;
            pll_fraction_mid          <= `RST_PLL_FRAC_MID;
            pll_fraction_low          <= `RST_PLL_FRAC_LOW;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `ADDR_POWER_ONE:     power_control_one         <= REG_WDATA;
                `ADDR_COMPANDER:     compander_and_return_path <= REG_WDATA;
                `ADDR_CLOCK_GEN:     clock_generation          <= REG_WDATA;
                `ADDR_SAMPLE_RATE:   sample_rate_config        <= REG_WDATA;
                `ADDR_PIN_FUNCTION:  pin_function_control      <= REG_WDATA;
                `ADDR_PLL_INTEGER:   pll_integer_ratio         <= REG_WDATA;
                `ADDR_PLL_FRAC_HIGH: pll_fraction_high         <= REG_WDATA;
                `ADDR_PLL_FRAC_MID:  pll_fraction_mid          <= REG_WDATA;
                `ADDR_PLL_FRAC_LOW:  pll_fraction_low          <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // Registered read-back
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 9'h000;
        end else begin
            case (REG_ADDR)
                `ADDR_POWER_ONE:     REG_RDATA <= power_control_one;
                `ADDR_COMPANDER:     REG_RDATA <= compander_and_return_path;
                `ADDR_CLOCK_GEN:     REG_RDATA <= clock_generation;
                `ADDR_SAMPLE_RATE:   REG_RDATA <= sample_rate_config;
                `ADDR_PIN_FUNCTION:  REG_RDATA <= pin_function_control;
                `ADDR_PLL_INTEGER:   REG_RDATA <= pll_integer_ratio;
                `ADDR_PLL_FRAC_HIGH: REG_RDATA <= pll_fraction_high;
                `ADDR_PLL_FRAC_MID:  REG_RDATA <= pll_fraction_mid;
                `ADDR_PLL_FRAC_LOW:  REG_RDATA <= pll_fraction_low;
                default:             REG_RDATA <= 9'h000;
            endcase
        end
    end

    // Settings to PLL and filters
    assign PLL_ENABLE       = power_control_one[`BIT_PLL_ENABLE];
    assign PLL_N            = pll_integer_ratio[`FLD_PLL_N];
    assign PLL_K            = {pll_fraction_high[`FLD_FRAC_HIGH],
                               pll_fraction_mid, pll_fraction_low};
    assign FILTER_RATE_CODE = sample_rate_config[`FLD_RATE_CODE];

    ////////////////////
    // PLL reference and PLL output path

    reg        mclk_q;
    reg        osc_q;
    reg  [3:0] osc_cnt;
    reg        pll_clk_ev;
    wire       mclk_ev;
    wire [3:0] pll_halves;

    assign mclk_ev    = MCLK ^ mclk_q;
    assign pll_halves = PLL_POST_DIV2 ? `PLL_POST_HALVES : `PLL_FIXED_HALVES;

    // Reference halver and PLL oscillator divider
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mclk_q      <= 1'b0;
            osc_q       <= 1'b0;
            osc_cnt     <= 4'h0;
            pll_clk_ev  <= 1'b0;
            PLL_REF_CLK <= 1'b0;
        end else begin
            mclk_q     <= MCLK;
            osc_q      <= PLL_OSC;
            pll_clk_ev <= 1'b0;
            if (!pll_integer_ratio[`BIT_INPUT_HALVER])
                PLL_REF_CLK <= MCLK;
            else if (MCLK && !mclk_q)
                PLL_REF_CLK <= ~PLL_REF_CLK;
            if (!PLL_ENABLE) begin
                osc_cnt <= 4'h0;
            end else if (PLL_OSC ^ osc_q) begin
                if (osc_cnt + 4'h1 >= pll_halves) begin
                    osc_cnt    <= 4'h0;
                    pll_clk_ev <= 1'b1;
                end else begin
                    osc_cnt <= osc_cnt + 4'h1;
                end
            end
        end
    end

    ////////////////////
    // System clock scaler and master bit clock / frame generation

    reg        act_master;
    reg        act_source;
    reg  [2:0] act_scaler;
    reg  [2:0] act_bclk;
    reg  [4:0] scale_acc;
    reg  [4:0] scale_lim;
    reg        sys_half_ev;
    reg        sys_phase;
    reg  [4:0] bclk_cnt;
    reg  [9:0] frame_cnt;
    reg  [5:0] bclk_halves;
    wire       src_ev;
    wire       frame_wrap;
    wire [4:0] scale_next;

    assign src_ev     = act_source ? pll_clk_ev : mclk_ev;
    assign scale_next = scale_acc + 5'h02;
    assign frame_wrap = sys_half_ev && (frame_cnt == `FRAME_HALVES);

    // Scaler limit in source half units
    always @* begin
        case (act_scaler)
            3'h0:    scale_lim = 5'h02;
            3'h1:    scale_lim = 5'h03;
            3'h2:    scale_lim = 5'h04;
            3'h3:    scale_lim = 5'h06;
            3'h4:    scale_lim = 5'h08;
            3'h5:    scale_lim = 5'h0c;
            3'h6:    scale_lim = 5'h10;
            default: scale_lim = 5'h18;
        endcase
    end

    // Bit clock half period; reserved codes act as 32
    always @* begin
        if (act_bclk > `BCLK_CODE_MAX)
            bclk_halves = 6'h20;
        else
            bclk_halves = 6'h01 << act_bclk;
    end

    // Settings taken at frame end or while idle
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            act_master <= 1'b0;
            act_source <= 1'b1;
            act_scaler <= 3'h2;
            act_bclk   <= 3'h0;
        end else if (frame_wrap || !act_master) begin
            act_master <= clock_generation[`BIT_MASTER_SELECT];
            act_source <= clock_generation[`BIT_CLOCK_SOURCE];
            act_scaler <= clock_generation[`FLD_SCALER];
            act_bclk   <= clock_generation[`FLD_BCLK_DIV];
        end
    end

    // System clock half-period events
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            scale_acc   <= 5'h00;
            sys_half_ev <= 1'b0;
            sys_phase   <= 1'b0;
            SYS_CLK_EN  <= 1'b0;
        end else begin
            sys_half_ev <= 1'b0;
            SYS_CLK_EN  <= 1'b0;
            if (src_ev) begin
                if (scale_next >= scale_lim) begin
                    scale_acc   <= scale_next - scale_lim;
                    sys_half_ev <= 1'b1;
                    sys_phase   <= ~sys_phase;
                    SYS_CLK_EN  <= ~sys_phase;
                end else begin
                    scale_acc <= scale_next;
                end
            end
        end
    end

    // Bit clock and frame, 256 system clocks per frame
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            bclk_cnt  <= 5'h00;
            frame_cnt <= 10'h000;
            BCLK_OUT  <= 1'b0;
            FRAME_OUT <= 1'b0;
        end else if (!act_master) begin
            bclk_cnt  <= 5'h00;
            frame_cnt <= 10'h000;
            BCLK_OUT  <= 1'b0;
            FRAME_OUT <= 1'b0;
        end else if (sys_half_ev) begin
            if (frame_wrap) begin
                frame_cnt <= 10'h000;
                bclk_cnt  <= 5'h00;
                BCLK_OUT  <= 1'b0;
            end else begin
                frame_cnt <= frame_cnt + 10'h001;
                if ({1'b0, bclk_cnt} + 6'h01 >= bclk_halves) begin
                    bclk_cnt <= 5'h00;
                    BCLK_OUT <= ~BCLK_OUT;
                end else begin
                    bclk_cnt <= bclk_cnt + 5'h01;
                end
            end
            FRAME_OUT <= (frame_cnt + 10'h001 < `FRAME_HIGH_HALVES) || frame_wrap;
        end
    end

    // Pins driven only in master mode
    assign BCLK_OE_N  = ~act_master;
    assign FRAME_OE_N = ~act_master;

    ////////////////////
    // Companding and return path

    wire [1:0]  rec_law;
    wire [1:0]  play_law;
    wire        rec_on;
    wire        play_on;
    wire        loop_on;
    wire [7:0]  rec_code;
    wire [15:0] play_linear;
    wire [15:0] rec_word_next;
    wire [15:0] play_src;
    wire        play_src_valid;

    assign rec_law  = compander_and_return_path[`FLD_REC_LAW];
    assign play_law = compander_and_return_path[`FLD_PLAY_LAW];
    assign rec_on   = (rec_law == `LAW_MU) || (rec_law == `LAW_A);
    assign play_on  = (play_law == `LAW_MU) || (play_law == `LAW_A);
    assign loop_on  = compander_and_return_path[`BIT_RETURN_PATH];

    assign rec_word_next  = rec_on ? {rec_code, 8'h00} : REC_SAMPLE;
    assign play_src       = loop_on ? REC_WORD : PLAY_WORD;
    assign play_src_valid = loop_on ? REC_WORD_VALID : PLAY_VALID;

    g711_compander u_compander (
        .rec_law     (rec_law),
        .rec_linear  (REC_SAMPLE),
        .rec_code    (rec_code),
        .play_law    (play_law),
        .play_code   (play_src[15:8]),
        .play_linear (play_linear)
    );

    // Record word and playback sample registers
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            REC_WORD_VALID    <= 1'b0;
            REC_WORD          <= 16'h0000;
            PLAY_SAMPLE_VALID <= 1'b0;
            PLAY_SAMPLE       <= 16'h0000;
        end else begin
            REC_WORD_VALID    <= REC_VALID;
            PLAY_SAMPLE_VALID <= play_src_valid;
            if (REC_VALID)
                REC_WORD <= rec_word_next;
            if (play_src_valid)
                PLAY_SAMPLE <= play_on ? play_linear : play_src;
        end
    end

    ////////////////////
    // Multi-function pin

    wire [2:0] pin_sel;
    wire       alt_pin;
    reg  [1:0] opclk_cnt;
    reg        opclk;

    assign pin_sel = pin_function_control[`FLD_PIN_SELECT];
    assign alt_pin = !CTRL_MODE && (pin_sel != `PIN_CHIP_SELECT);
    assign MFP_OE_N      = ~alt_pin;
    assign CHIP_SELECT_N = alt_pin ? 1'b1 : MFP_IN;

    // PLL clock divided by 1 to 4 for the pin
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            opclk_cnt <= 2'h0;
            opclk     <= 1'b0;
        end else if (pll_clk_ev) begin
            if (opclk_cnt >= pin_function_control[`FLD_OUT_CLK_DIV]) begin
                opclk_cnt <= 2'h0;
                opclk     <= ~opclk;
            end else begin
                opclk_cnt <= opclk_cnt + 2'h1;
            end
        end
    end

    // Pin output selection
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            MFP_OUT <= 1'b0;
        end else begin
            case (pin_sel)
                `PIN_JACK_DETECT: MFP_OUT <= JACK_DETECT;
                `PIN_TEMP_OK:     MFP_OUT <= TEMP_OK;
                `PIN_AUTO_MUTE:   MFP_OUT <= AUTO_MUTE;
                `PIN_PLL_CLOCK:   MFP_OUT <= opclk;
                `PIN_PLL_LOCK:    MFP_OUT <= PLL_LOCK;
                default:          MFP_OUT <= 1'b0;
            endcase
        end
    end

endmodule

/* core/audio_port_map.vh */
// Register map and constants of the audio port
`ifndef AUDIO_PORT_MAP_VH
`define AUDIO_PORT_MAP_VH

// Register indices
`define ADDR_SOFT_RESET      7'h00
`define ADDR_POWER_ONE       7'h01
`define ADDR_COMPANDER       7'h05
`define ADDR_CLOCK_GEN       7'h06
`define ADDR_SAMPLE_RATE     7'h07
`define ADDR_PIN_FUNCTION    7'h08
`define ADDR_PLL_INTEGER     7'h24
`define ADDR_PLL_FRAC_HIGH   7'h25
`define ADDR_PLL_FRAC_MID    7'h26
`define ADDR_PLL_FRAC_LOW    7'h2c

// Reset values
`define RST_POWER_ONE        9'h000
`define RST_COMPANDER        9'h000
`define RST_CLOCK_GEN        9'h140
`define RST_SAMPLE_RATE      9'h000
`define RST_PIN_FUNCTION     9'h000
`define RST_PLL_INTEGER      9'h008
`define RST_PLL_FRAC_HIGH    9'h00c
`define RST_PLL_FRAC_MID     9'h093
`define RST_PLL_FRAC_LOW     9'h0e9

// Field positions
`define BIT_MASTER_SELECT    0
`define BIT_PLL_ENABLE       5
`define BIT_CLOCK_SOURCE     8
`define BIT_RETURN_PATH      0
`define BIT_INPUT_HALVER     4
`define FLD_BCLK_DIV         4:2
`define FLD_SCALER           7:5
`define FLD_REC_LAW          2:1
`define FLD_PLAY_LAW         4:3
`define FLD_RATE_CODE        3:1
`define FLD_PIN_SELECT       2:0
`define FLD_OUT_CLK_DIV      5:4
`define FLD_PLL_N            3:0
`define FLD_FRAC_HIGH        5:0

// Compander law codes
`define LAW_OFF              2'h0
`define LAW_MU               2'h2
`define LAW_A                2'h3

// Pin function codes
`define PIN_CHIP_SELECT      3'h0
`define PIN_JACK_DETECT      3'h1
`define PIN_TEMP_OK          3'h2
`define PIN_AUTO_MUTE        3'h3
`define PIN_PLL_CLOCK        3'h4
`define PIN_PLL_LOCK         3'h5

// Clock path half-period counts and largest bit clock divider code
`define FRAME_HALVES         10'h1ff
`define FRAME_HIGH_HALVES    10'h100
`define PLL_FIXED_HALVES     4'h4
`define PLL_POST_HALVES      4'h8
`define BCLK_CODE_MAX        3'h5

`endif

/* core/g711_compander.v */
// G.711 compressor and expander
`timescale 1ns/1ns
`include "audio_port_map.vh"

module g711_compander (
    input  wire [1:0]  rec_law,
    input  wire [15:0] rec_linear,
    output wire [7:0]  rec_code,
    input  wire [1:0]  play_law,
    input  wire [7:0]  play_code,
    output wire [15:0] play_linear
);

    // Linear to code, 13-bit magnitude for mu, 12-bit for A
    function [7:0] compress;
        input [1:0]  law;
        input [15:0] s;
        reg          neg;
        reg   [15:0] mag;
        reg   [2:0]  seg;
        reg   [3:0]  mant;
        integer      i;
        begin
            neg  = s[15];
            seg  = 3'h0;
            if (law == `LAW_MU) begin
                mag = neg ? (~s + 16'h0001) : s;
                mag = {2'h0, mag[15:2]};
                if (mag > 16'h1fde)
                    mag = 16'h1fde;
                mag = mag + 16'h0021;
                for (i = 0; i < 8; i = i + 1)
                    if (mag[i+5])
                        seg = i[2:0];
                mant = mag[seg+1 +: 4];
                compress = ~{neg, seg, mant};
            end else begin
                mag = neg ? ~s : s;
                mag = {3'h0, mag[15:3]};
                for (i = 1; i < 8; i = i + 1)
                    if (mag[i+4])
                        seg = i[2:0];
                mant = (seg == 3'h0) ? mag[4:1] : mag[seg +: 4];
                compress = {~neg, seg, mant} ^ 8'h55;
            end
        end
    endfunction

    // Code to linear on the full 16-bit scale
    function [15:0] expand;
        input [1:0] law;
        input [7:0] c;
        reg   [7:0]  u;
        reg   [15:0] t;
        begin
            if (law == `LAW_MU) begin
                u = ~c;
                t = ({9'h000, u[3:0], 3'h0} + 16'h0084) << u[6:4];
                expand = u[7] ? (16'h0084 - t) : (t - 16'h0084);
            end else begin
                u = c ^ 8'h55;
                t = {8'h00, u[3:0], 4'h0};
                if (u[6:4] == 3'h0)
                    t = t + 16'h0008;
                else
                    t = (t + 16'h0108) << (u[6:4] - 3'h1);
                expand = u[7] ? t : (~t + 16'h0001);
            end
        end
    endfunction

    // Sign, three-bit segment, four-bit step in each code
    assign rec_code    = compress(rec_law, rec_linear);
    assign play_linear = expand(play_law, play_code);

endmodule

/* dv/audio_port_checker_assertions.sv */
// Port-level assertions for the audio port clocking block
`timescale 1ns/1ns
module audio_port_checker (
    input wire       CLK_SYS,
    input wire       RESET_N,
    input wire       REG_WE,
    input wire [6:0] REG_ADDR,
    input wire [8:0] REG_WDATA,
    input wire [3:0] PLL_N,
    input wire       PLL_ENABLE,
    input wire       BCLK_OUT,
    input wire       BCLK_OE_N,
    input wire       FRAME_OUT,
    input wire       FRAME_OE_N,
    input wire       REC_VALID,
    input wire       REC_WORD_VALID,
    input wire       CTRL_MODE,
    input wire       MFP_OE_N
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    ////////////////////
    a_oe_pair: assert property (BCLK_OE_N == FRAME_OE_N)
        else $error("clock enables differ");
    a_slave_quiet: assert property (BCLK_OE_N && $past(BCLK_OE_N) |-> !BCLK_OUT && !FRAME_OUT)
        else $error("slave drives clocks");
    a_master_entry: assert property (REG_WE && REG_ADDR == 7'h06 && REG_WDATA[0]
        && BCLK_OE_N |-> ##2 !BCLK_OE_N) else $error("master entry late");
    a_rec_latency: assert property (REC_VALID |=> REC_WORD_VALID)
        else $error("record word missing");
    a_rec_source: assert property (REC_WORD_VALID |-> $past(REC_VALID))
        else $error("record word unasked");
    a_ratio_write: assert property (REG_WE && REG_ADDR == 7'h24 |=> PLL_N == $past(REG_WDATA[3:0]))
        else $error("integer ratio wrong");
    a_pll_power: assert property (REG_WE && REG_ADDR == 7'h01 |=> PLL_ENABLE == $past(REG_WDATA[5]))
        else $error("pll enable wrong");
    a_three_wire: assert property (CTRL_MODE [*4] |-> MFP_OE_N)
        else $error("pin driven in 3-wire");
    c_master: cover property ($fell(BCLK_OE_N));
    c_record: cover property (REC_WORD_VALID);
    c_pin_out: cover property (!MFP_OE_N);
endmodule

bind audio_port_clocking audio_port_checker chk (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .PLL_N(PLL_N), .PLL_ENABLE(PLL_ENABLE), .BCLK_OUT(BCLK_OUT),
    .BCLK_OE_N(BCLK_OE_N), .FRAME_OUT(FRAME_OUT), .FRAME_OE_N(FRAME_OE_N),
    .REC_VALID(REC_VALID), .REC_WORD_VALID(REC_WORD_VALID), .CTRL_MODE(CTRL_MODE),
    .MFP_OE_N(MFP_OE_N));

/* dv/host_serial_port.sv */
// Host serial port model facing bit clock and frame sync
`timescale 1ns/1ns
module host_serial_port (
    input  wire        clk,
    input  wire        bclk_oe_n,
    input  wire        bclk_out,
    output reg         bclk_in = 1'b0,
    output reg         frame_in = 1'b0,
    output reg  [15:0] bclk_edges = 16'h0000
);
    reg       last = 1'b0;
    reg [3:0] div = 4'h0;
    // Slave clocks; edge count in master
    always @(posedge clk) begin
        last <= bclk_out;
        div <= div + 4'h1;
        if (bclk_oe_n) begin
            bclk_in <= div[1];
            frame_in <= div[3];
        end else begin
            bclk_in <= div[0];
            frame_in <= ~div[0];
            if (bclk_out != last)
                bclk_edges <= bclk_edges + 16'h1;
        end
    end
endmodule

/* dv/tb_audio_port_clocking.sv */
// Self-checking bench for the audio port clocking block
`timescale 1ns/1ns
module tb_audio_port_clocking;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg         we = 1'b0;
    reg  [6:0]  addr = 7'h00;
    reg  [8:0]  wdata = 9'h000;
    reg         mclk = 1'b0;
    reg         osc = 1'b0;
    reg         rv = 1'b0;
    reg  [15:0] rs = 16'h0000;
    reg         pv = 1'b0;
    reg  [15:0] pw = 16'h1234;
    reg         mode = 1'b0;
    reg         lvl = 1'b0;
    reg         drv = 1'b0;
    integer     miscompares = 0;
    integer     n_tests = 0;
    integer     cycles = 0;
    wire [8:0]  rdata;
    wire [3:0]  pll_n;
    wire [23:0] pll_k;
    wire [15:0] rw, ps, edges;
    wire        ref_clk, bo, boe, fo, foe, bi, fi, rwv, psv, mo, moe, cs_n;
    wire        pin = moe ? drv : mo;
    // Samples, expected record words per law, register defaults
    localparam [47:0]  SMP = {16'h8000, 16'h7fff, 16'h0000};
    localparam [191:0] EXP = {48'h2a00aa00d500, 48'h00008000ff00, 48'h80007fff0000,
                              48'h80007fff0000};
    localparam [159:0] ROWS = {16'h0200, 16'h0a00, 16'h0d40, 16'h0e00, 16'h1000, 16'h4808,
                               16'h4a0c, 16'h4c93, 16'h58e9, 16'h0400};
    ////////////////////
    // System, master and oscillator clocks
    always #4 clk_sys = ~clk_sys;
    always #16 mclk = ~mclk;
    always #24 osc = ~osc;
    audio_port_clocking uut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_WE(we), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .MCLK(mclk), .PLL_OSC(osc),
        .PLL_POST_DIV2(1'b0), .PLL_REF_CLK(ref_clk), .PLL_ENABLE(), .PLL_N(pll_n),
        .PLL_K(pll_k), .SYS_CLK_EN(), .FILTER_RATE_CODE(), .BCLK_IN(bi), .BCLK_OUT(bo),
        .BCLK_OE_N(boe), .FRAME_IN(fi), .FRAME_OUT(fo), .FRAME_OE_N(foe), .REC_VALID(rv),
        .REC_SAMPLE(rs), .REC_WORD_VALID(rwv), .REC_WORD(rw), .PLAY_VALID(pv),
        .PLAY_WORD(pw), .PLAY_SAMPLE_VALID(psv), .PLAY_SAMPLE(ps), .CTRL_MODE(mode),
        .JACK_DETECT(lvl), .TEMP_OK(lvl), .AUTO_MUTE(lvl), .PLL_LOCK(lvl), .MFP_IN(pin),
        .MFP_OUT(mo), .MFP_OE_N(moe), .CHIP_SELECT_N(cs_n));
    host_serial_port host (.clk(clk_sys), .bclk_oe_n(boe), .bclk_out(bo), .bclk_in(bi),
        .frame_in(fi), .bclk_edges(edges));
    ////////////////////
    // Compare, count and report
    task check(input [27:0] seen, input [27:0] exp, input [95:0] what);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task end_sim;
        begin
            $display("TB: %0d checks, %0d mismatches", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end
    // Register cycles, entered one step after an edge
    task wr(input [6:0] a, input [8:0] d);
        begin
            we = 1'b1;
            addr = a;
            wdata = d;
            @(posedge clk_sys) #1 we = 1'b0;
            @(posedge clk_sys) #1;
        end
    endtask
    task rd(input [6:0] a, output [8:0] d);
        begin
            addr = a;
            @(posedge clk_sys) #1 d = rdata;
        end
    endtask
    // Waits for a frame level, counting cycles
    task wait_frame(input v, output integer n);
        for (n = 0; fo !== v && n < 3000; n = n + 1)
            @(posedge clk_sys) #1;
    endtask
    ////////////////////
    task t_defaults;
        integer i;
        reg [8:0] d;
        for (i = 0; i < 10; i = i + 1) begin
            rd(ROWS[i*16+9 +: 7], d);
            check(d, ROWS[i*16 +: 9], "default");
        end
    endtask
    task t_pll;
        integer n;
        reg [8:0] d;
        begin
            wr(7'h24, 9'h017);
            wr(7'h25, 9'h021);
            wr(7'h26, 9'h161);
            wr(7'h2c, 9'h027);
            check({pll_n, pll_k}, {4'h7, 24'h86c227}, "ratio");
            rd(7'h26, d);
            check(d, 9'h161, "readback");
            wr(7'h02, 9'h1ff);
            rd(7'h02, d);
            check(d, 9'h000, "unmapped");
            n = 0;
            repeat (400) begin
                @(posedge clk_sys) #1 n = n + (ref_clk !== d[0]);
                d[0] = ref_clk;
            end
            check(n > 98 && n < 102, 1'b1, "ref halved");
            $display("TB: pll done");
        end
    endtask
    task t_compand;
        integer l;
        integer s;
        begin
            for (l = 0; l < 4; l = l + 1)
                for (s = 0; s < 3; s = s + 1) begin
                    wr(7'h05, {6'h00, l[1:0], 1'b0});
                    rs = SMP[s*16 +: 16];
                    rv = 1'b1;
                    @(posedge clk_sys) #1 rv = 1'b0;
                    check({rwv, rw}, {1'b1, EXP[(l*3+s)*16 +: 16]}, "record");
                end
            wr(7'h05, 9'h015);
            rs = 16'h0000;
            rv = 1'b1;
            @(posedge clk_sys) #1 rv = 1'b0;
            @(posedge clk_sys) #1;
            check({psv, ps}, {1'b1, 16'h0000}, "loopback");
            wr(7'h05, 9'h000);
            pv = 1'b1;
            @(posedge clk_sys) #1 pv = 1'b0;
            check({psv, ps}, {1'b1, 16'h1234}, "play");
            $display("TB: compand done");
        end
    endtask
    task t_pin;
        integer c;
        begin
            wr(7'h01, 9'h020);
            for (c = 2; c < 12; c = c + 1) if (c / 2 != 4) begin
                if (!c[0]) wr(7'h08, c[9:1]);
                lvl = c[0];
                repeat (3) @(posedge clk_sys) #1;
                check({moe, mo}, {1'b0, c[0]}, "pin level");
            end
            wr(7'h08, 9'h000);
            check({moe, cs_n}, 2'b10, "chip select");
            wr(7'h08, 9'h001);
            mode = 1'b1;
            repeat (5) @(posedge clk_sys) #1;
            check({moe, cs_n}, 2'b10, "three wire");
            $display("TB: pin done");
        end
    endtask
    task t_master;
        integer n;
        reg [15:0] e0;
        begin
            wr(7'h06, 9'h005);
            check({boe, foe}, 2'b00, "master");
            e0 = edges;
            repeat (400) @(posedge clk_sys) #1;
            check(edges - e0 > 98 && edges - e0 < 102, 1'b1, "bclk rate");
            wait_frame(1'b0, n);
            wait_frame(1'b1, n);
            wait_frame(1'b0, n);
            check(n, 512, "frame high");
            wait_frame(1'b1, n);
            check(n, 512, "frame low");
            $display("TB: master done");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_sys) #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk_sys) #1;
        t_defaults;
        t_pll;
        t_compand;
        t_pin;
        t_master;
        wr(7'h00, 9'h000);
        t_defaults;
        end_sim;
    end
endmodule
